//--- logic/msg_pkg.sv
// Shared constants and types for the data-port block message decoder
package msg_pkg;

   // Register and element widths
   localparam int REG_W     = 256; // Thread register width
   localparam int DW_N      = 8; // Dwords per register
   localparam int EXEC_W    = 16; // Execution mask width
   localparam int OUT_W     = REG_W + DW_N + 2; // Data, enables, last, write
   localparam int FIFO_DEPTH = 16; // Words held in the output FIFO

   // Descriptor field positions
   localparam int DESC_INVAL_BIT = 13; // Invalidate after read
   localparam int DESC_RET_BIT   = 13; // Return data enable (atomics)
   localparam int DESC_SUB_HI    = 12; // Block sub-type msb
   localparam int DESC_SUB_LO    = 11; // Block sub-type lsb
   localparam int DESC_BSZ_HI    = 10; // Block size msb
   localparam int DESC_BSZ_LO    = 8; // Block size lsb
   localparam int DESC_SIMD_BIT  = 12; // Float add: 1 = SIMD8
   localparam int DESC_QW_BIT    = 11; // Float add: 1 = qword

   // Header field positions
   localparam int HDR_CHMODE_BIT = 31; // Dword 5: channel mode
   localparam int PMASK_W        = 16; // Dword 7: pixel mask width

   // Block sub-type codes
   localparam logic [1:0] SUB_OWORD = 2'h0; // Aligned OWord
   localparam logic [1:0] SUB_UNAL  = 2'h1; // Unaligned OWord read
   localparam logic [1:0] SUB_DUAL  = 2'h2; // Dual OWord
   localparam logic [1:0] SUB_HWORD = 2'h3; // HWord

   // Block size codes
   localparam logic [2:0] BSZ_LOW  = 3'h0; // One OWord low / reserved
   localparam logic [2:0] BSZ_ONE  = 3'h1; // One OWord high / one unit
   localparam logic [2:0] BSZ_TWO  = 3'h2; // Two units
   localparam logic [2:0] BSZ_FOUR = 3'h3; // Four units
   localparam logic [2:0] BSZ_EIGHT = 3'h4; // Eight units

   // Reset values
   localparam logic [3:0] RST_COUNT = 4'h0; // Register counter at reset

   // Message kinds presented by the issuing thread
   typedef enum logic [1:0] {
      KIND_BLOCK, // OWord / dual / HWord block
      KIND_CMPWR64, // SIMD4x2 64-bit compare-write
      KIND_FADD, // Untyped atomic float add
      KIND_NONE // Unused code
   } kind_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE, // Waiting for a message
      ST_RUN, // Moving register beats
      ST_DONE // Reporting completion
   } state_t;

endpackage

//--- logic/fifo_if.sv
// Valid/ready carrier between the decoder and its output FIFO
`timescale 1ns/1ps
interface fifo_if #(
   parameter int WIDTH = 8,                 // Word width
   parameter int DEPTH = 16                 // Words held
);
   logic                     in_valid;      // Push request
   logic                     in_ready;      // Room available
   logic [WIDTH-1:0]         in_data;       // Pushed word
   logic                     out_valid;     // Word available
   logic                     out_ready;     // Pop request
   logic [WIDTH-1:0]         out_data;      // Word at the head
   logic [$clog2(DEPTH):0]   level;         // Words currently held

   modport producer (output in_valid, in_data, out_ready,
                     input  in_ready, out_valid, out_data, level);
   modport store    (input  in_valid, in_data, out_ready,
                     output in_ready, out_valid, out_data, level);
endinterface

//--- logic/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 8,                 // Word width
   parameter int DEPTH = 16                 // Words held
) (
   input  wire logic clk,                   // Core clock
   input  wire logic rst_n,                 // Synchronised reset, low
   input  wire logic ce,                    // Clock enable
   fifo_if.store     f                      // Push and pop sides
);
   localparam int AW = $clog2(DEPTH); // Pointer width

   logic [WIDTH-1:0] mem [DEPTH]; // Word storage
   logic [AW-1:0]    wr_ptr; // Write pointer
   logic [AW-1:0]    rd_ptr; // Read pointer
   logic [AW:0]      count; // Fill level
   logic             push; // Accepted write
   logic             pop; // Accepted read

   // Honest full and empty
   assign f.in_ready  = (count != (AW+1)'(DEPTH));
   assign f.out_valid = (count != '0);
   assign f.out_data  = mem[rd_ptr];
   assign f.level     = count;
   assign push        = f.in_valid && f.in_ready;
   assign pop         = f.out_valid && f.out_ready;

   // Storage write
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wr_ptr] <= f.in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // word_fifo

//--- logic/data_port_block_message_decode.sv
// Data-port block message decoder and writeback formatter
`timescale 1ns/1ps
// Behaviour
// R1 - Compare-write writeback only when return enabled
// R2 - Only exec-enabled channels get overwritten
// R3 - Compare-write slots in dwords 0,1 and 4,5
// R4 - Invalidate touched lines after read
// R5 - Invalidate bit ignored on writes
// R6 - Bits 12:11 pick block sub-type
// R7 - Bits 10:8 give element count
// R8 - Single OWord codes pick low/high half
// R9 - Dual OWord allows one or four only
// R10 - Dual read: block 0 low, block 1 high
// R11 - HWord channel mode 0: OWord nibble enables
// R12 - HWord channel mode 1: per-dword enables
// R13 - Thread gives block 0 offset, dwords 1:0
// R14 - Thread gives block 1 offset, dwords 3:2
// R15 - Thread keeps HWord offset canonical
// R16 - Single write takes selected payload half
// R17 - OWord read elements fill ascending halves
// R18 - High-half single write is element zero
// R19 - HWord: one HWord per register
// R20 - Float add bit 13 enables return
// R21 - Float add bit 12 SIMD, bit 11 size
// R22 - Pixel mask gates untyped slots
// R23 - Reserved codes give no writeback
module data_port_block_message_decode #(
   parameter int WIDTH = msg_pkg::REG_W,    // Register width
   parameter int DEPTH = msg_pkg::FIFO_DEPTH // Output FIFO depth
) (
   input  wire logic              clk, // Core clock, 10 MHz
   input  wire logic              rst_n, // Async reset, low
   input  wire logic              ce, // Clock enable
   input  wire logic              msg_valid, // Message offered
   output logic                   msg_ready, // Message taken when high
   input  wire msg_pkg::kind_t    msg_kind, // Message kind
   input  wire logic              msg_write, // 1 = write message
   input  wire logic [31:0]       msg_desc, // Message descriptor
   input  wire logic              hdr_present, // Header was sent
   input  wire logic [31:0]       hdr_dw5, // Header dword 5
   input  wire logic [31:0]       hdr_dw7, // Header dword 7
   input  wire logic [63:0]       hdr_off0, // Header dwords 1:0
   input  wire logic [63:0]       hdr_off1, // Header dwords 3:2
   input  wire logic [15:0]       exec_mask, // Send execution mask
   input  wire logic              beat_valid, // Data beat offered
   output logic                   beat_ready, // Data beat taken when high
   input  wire logic [WIDTH-1:0]  beat_data, // Memory or payload data
   output logic                   out_valid, // Output word valid
   input  wire logic              out_ready, // Output word taken
   output logic [WIDTH-1:0]       out_data, // Register or memory word
   output logic [7:0]             out_dw_en, // Per-dword enables
   output logic                   out_last, // Last word of message
   output logic                   out_write, // Word is write data
   output logic                   inval_after_read, // Invalidate lines
   output logic [63:0]            block_off0, // Block 0 byte offset
   output logic [63:0]            block_off1, // Block 1 byte offset
   output logic                   msg_error, // Reserved code pulse
   output logic                   msg_done // Message finished pulse
);
   localparam int OW = WIDTH + 10; // FIFO word width
   localparam int HALF = WIDTH / 2; // One OWord

   logic             rst_meta; // Reset sync stage 1
   logic             rst_sync_n; // Reset for the design
   msg_pkg::state_t  state; // Sequencer state
   msg_pkg::state_t  next_state; // Next sequencer state
   logic [3:0]       nregs; // Registers to move
   logic [3:0]       count; // Registers moved
   logic [1:0]       sub; // Latched sub-type
   msg_pkg::kind_t   kind; // Latched kind
   logic             wr; // Latched write flag
   logic             single; // Single-OWord transfer
   logic             hi_half; // Single uses high half
   logic             chmode; // HWord dword mode
   logic [15:0]      emask; // Effective slot mask
   logic             qword; // Float add qword size
   logic             simd8; // Float add SIMD8
   // Decode of the offered message
   logic [3:0]       dec_n; // Register count
   logic             dec_err; // Reserved combination
   logic [2:0]       bsz; // Block size field
   logic [1:0]       dsub; // Sub-type field
   logic [15:0]      pmask; // Pixel mask in effect
   // Output formatting
   logic [7:0]       ex8; // Exec bits for register
   logic [7:0]       nib_en; // OWord nibble enables
   logic [7:0]       f_en; // Formatted enables
   logic [WIDTH-1:0] f_data; // Formatted data
   logic             take; // Beat accepted
   logic             take_msg; // Message accepted
   logic             out_pop; // Move FIFO head out

   fifo_if #(.WIDTH(OW), .DEPTH(DEPTH)) fq (); // Output path carrier

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   assign bsz  = msg_desc[msg_pkg::DESC_BSZ_HI:msg_pkg::DESC_BSZ_LO];
   assign dsub = msg_desc[msg_pkg::DESC_SUB_HI:msg_pkg::DESC_SUB_LO];
   assign take_msg = msg_valid && msg_ready;
   assign take = beat_valid && beat_ready;

   // Register count and legality of the offered message
   always_comb begin
      dec_n   = 4'h0;
      dec_err = 1'b0;
      pmask   = hdr_present ? hdr_dw7[msg_pkg::PMASK_W-1:0] : 16'hffff;
      case (msg_kind)
         msg_pkg::KIND_BLOCK: begin
            // R6 sub-type decode
            case (dsub)
               msg_pkg::SUB_OWORD, msg_pkg::SUB_UNAL: begin
                  // R7 OWord element counts
                  case (bsz)
                     msg_pkg::BSZ_LOW, msg_pkg::BSZ_ONE: dec_n = 4'h1;
                     msg_pkg::BSZ_TWO:   dec_n = 4'h1;
                     msg_pkg::BSZ_FOUR:  dec_n = 4'h2;
                     msg_pkg::BSZ_EIGHT: dec_n = 4'h4;
                     default:            dec_err = 1'b1;
                  endcase
                  // Unaligned form exists for reads only
                  if (dsub == msg_pkg::SUB_UNAL && msg_write) begin
                     dec_err = 1'b1;
                  end
               end
               msg_pkg::SUB_DUAL: begin
                  // R9 one or four per block only
                  case (bsz)
                     msg_pkg::BSZ_ONE:  dec_n = 4'h1;
                     msg_pkg::BSZ_FOUR: dec_n = 4'h4;
                     default:           dec_err = 1'b1;
                  endcase
               end
               default: begin
                  // R7 HWord counts, low code 0 reserved (R8)
                  case (bsz)
                     msg_pkg::BSZ_ONE:   dec_n = 4'h1;
                     msg_pkg::BSZ_TWO:   dec_n = 4'h2;
                     msg_pkg::BSZ_FOUR:  dec_n = 4'h4;
                     msg_pkg::BSZ_EIGHT: dec_n = 4'h8;
                     default:            dec_err = 1'b1;
                  endcase
               end
            endcase
         end
         msg_pkg::KIND_CMPWR64: begin
            // R1 writeback only with return enabled
            dec_n = msg_desc[msg_pkg::DESC_RET_BIT] ? 4'h1 : 4'h0;
         end
         msg_pkg::KIND_FADD: begin
            // R20 return enable, R21 SIMD and size select
            if (msg_desc[msg_pkg::DESC_RET_BIT]) begin
               dec_n = msg_desc[msg_pkg::DESC_SIMD_BIT] ? 4'h1 : 4'h2;
               if (msg_desc[msg_pkg::DESC_QW_BIT]) begin
                  dec_n = {dec_n[2:0], 1'b0};
               end
            end
         end
         default: dec_err = 1'b1;
      endcase
      // R23 reserved codes move no data
      if (dec_err) begin
         dec_n = 4'h0;
      end
   end

   // Latch the message fields on acceptance
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         kind    <= msg_pkg::KIND_BLOCK;
         sub     <= msg_pkg::SUB_OWORD;
         wr      <= 1'b0;
         nregs   <= msg_pkg::RST_COUNT;
         single  <= 1'b0;
         hi_half <= 1'b0;
         chmode  <= 1'b0;
         emask   <= 16'h0;
         qword   <= 1'b0;
         simd8   <= 1'b0;
      end else if (ce && take_msg) begin
         kind    <= msg_kind;
         sub     <= dsub;
         wr      <= msg_write;
         nregs   <= dec_n;
         // R8 single OWord picks a register half
         single  <= (dsub == msg_pkg::SUB_OWORD || dsub == msg_pkg::SUB_UNAL)
                    && (bsz == msg_pkg::BSZ_LOW || bsz == msg_pkg::BSZ_ONE);
         hi_half <= bsz[0];
         chmode  <= hdr_dw5[msg_pkg::HDR_CHMODE_BIT];
         simd8   <= msg_desc[msg_pkg::DESC_SIMD_BIT];
         qword   <= msg_desc[msg_pkg::DESC_QW_BIT];
         // R22 pixel mask gates untyped slots, SIMD8 low half only
         if (msg_kind == msg_pkg::KIND_FADD) begin
            emask <= exec_mask & (msg_desc[msg_pkg::DESC_SIMD_BIT] ?
                     {8'h00, pmask[7:0]} : pmask);
         end else begin
            emask <= exec_mask;
         end
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         msg_pkg::ST_IDLE:
            if (take_msg) begin
               next_state = (dec_n == 4'h0) ? msg_pkg::ST_DONE : msg_pkg::ST_RUN;
            end
         msg_pkg::ST_RUN:
            if (take && count == nregs - 4'h1) begin
               next_state = msg_pkg::ST_DONE;
            end
         msg_pkg::ST_DONE: next_state = msg_pkg::ST_IDLE;
         default:          next_state = msg_pkg::ST_IDLE;
      endcase
   end

   // Sequencer state, counter and handshakes
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state      <= msg_pkg::ST_IDLE;
         count      <= msg_pkg::RST_COUNT;
         msg_ready  <= 1'b0;
         beat_ready <= 1'b0;
         msg_done   <= 1'b0;
         msg_error  <= 1'b0;
      end else if (ce) begin
         state     <= next_state;
         msg_ready <= (next_state == msg_pkg::ST_IDLE) && !take_msg;
         msg_done  <= (state == msg_pkg::ST_DONE);
         msg_error <= take_msg && dec_err;
         if (take_msg) begin
            count <= msg_pkg::RST_COUNT;
         end else if (take) begin
            count <= count + 4'h1;
         end
         // Stall the beat source once the FIFO would fill
         beat_ready <= (next_state == msg_pkg::ST_RUN) &&
                       (fq.level + (DEPTH < 2 ? 0 : 1) < DEPTH);
      end
   end

   // Exec bits for this register: even low byte, odd high byte
   assign ex8 = count[0] ? emask[15:8] : emask[7:0];
   // R11 any bit of a nibble enables the whole OWord
   assign nib_en = {{4{|ex8[7:4]}}, {4{|ex8[3:0]}}};

   // Format one beat into a register or memory word
   always_comb begin
      f_data = beat_data;
      f_en   = nib_en;
      case (kind)
         msg_pkg::KIND_CMPWR64: begin
            // R3 slot 0 in dwords 0,1 and slot 1 in dwords 4,5
            f_data = {64'h0, beat_data[127:64], 64'h0, beat_data[63:0]};
            // R2 only active slots are written
            f_en = {2'b00, {2{|emask[7:4]}}, 2'b00, {2{|emask[3:0]}}};
         end
         msg_pkg::KIND_FADD: begin
            // R2 qword high halves follow the low registers
            if (qword && !simd8) begin
               f_en = count[0] ? emask[15:8] : emask[7:0];
            end else if (qword) begin
               f_en = emask[7:0];
            end else begin
               f_en = ex8;
            end
         end
         default: begin
            if (sub == msg_pkg::SUB_HWORD) begin
               // R19 whole register per HWord; R12 dword enables
               f_en = chmode ? ex8 : nib_en;
            end else if (single && wr) begin
               // R16 R18 selected half is the element, other ignored
               f_data = {{HALF{1'b0}},
                         hi_half ? beat_data[WIDTH-1:HALF] :
                                   beat_data[HALF-1:0]};
               f_en = {4'h0, hi_half ? nib_en[7:4] : nib_en[3:0]};
            end else if (single) begin
               // R17 fill the selected half, keep the other
               f_data = hi_half ? {beat_data[HALF-1:0], {HALF{1'b0}}} :
                                  {{HALF{1'b0}}, beat_data[HALF-1:0]};
               f_en = hi_half ? {nib_en[7:4], 4'h0} : {4'h0, nib_en[3:0]};
            end
            // R10 R17 dual and multi reads pass block order as given
         end
      endcase
   end

   // Push formatted words into the FIFO
   assign fq.in_valid = take;
   assign fq.in_data  = {wr, (count == nregs - 4'h1), f_en, f_data};

   word_fifo #(.WIDTH(OW), .DEPTH(DEPTH)) u_fifo (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .ce    (ce),
      .f     (fq)
   );

   // Output stage registers the FIFO head
   assign out_pop      = !out_valid || out_ready;
   assign fq.out_ready = out_pop;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
         out_dw_en <= 8'h0;
         out_last  <= 1'b0;
         out_write <= 1'b0;
      end else if (ce && out_pop) begin
         out_valid <= fq.out_valid;
         {out_write, out_last, out_dw_en, out_data} <= fq.out_data;
      end
   end

   // Offsets and cache hint for the memory side
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         inval_after_read <= 1'b0;
         block_off0       <= 64'h0;
         block_off1       <= 64'h0;
      end else if (ce && take_msg) begin
         // R4 invalidate on reads; R5 never on writes
         inval_after_read <= msg_desc[msg_pkg::DESC_INVAL_BIT] &&
                             !msg_write && msg_kind == msg_pkg::KIND_BLOCK;
         // R13 R14 offsets as supplied; R15 range kept by the thread
         block_off0 <= hdr_off0;
         block_off1 <= hdr_off1;
      end
   end
endmodule // data_port_block_message_decode

//--- dv/data_port_block_message_decode_asserts.sv
// Port-level assertions for the block message decoder
`timescale 1ns/1ps
module data_port_block_message_decode_asserts (
   input wire logic           clk, rst_n, ce,  // Clock, reset, enable
   input wire logic           msg_valid, msg_ready, msg_write, // Request
   input wire msg_pkg::kind_t msg_kind,        // Message kind
   input wire logic [31:0]    msg_desc,        // Descriptor
   input wire logic [63:0]    hdr_off0, hdr_off1, block_off0, block_off1,
   input wire logic           beat_ready, out_valid, inval_after_read,
   input wire logic [7:0]     out_dw_en,       // Dword enables
   input wire logic           msg_error, msg_done // Status pulses
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire take = msg_valid && msg_ready && ce;   // Message accepted
   wire blk = msg_kind == msg_pkg::KIND_BLOCK; // Block message
   wire [1:0] sub = msg_desc[12:11];           // Block sub-type
   wire [2:0] bsz = msg_desc[10:8];            // Block size code
   msg_pkg::kind_t kind_q;                     // Kind in flight
   // Remember the kind of the accepted message
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) kind_q <= msg_pkg::KIND_BLOCK;
      else if (take) kind_q <= msg_kind;
   // Atomic taken without return data
   sequence s_noret;
      take && !msg_desc[13] && msg_kind inside {msg_pkg::KIND_CMPWR64,
         msg_pkg::KIND_FADD};
   endsequence
   // No beat moves, then completion
   sequence s_quiet_done; !beat_ready ##1 msg_done; endsequence
   property p_noret; s_noret |=> s_quiet_done; endproperty
   property p_busy; take |=> !msg_ready; endproperty
   property p_done; msg_done |=> !msg_done; endproperty
   property p_kind; take && msg_kind == msg_pkg::KIND_NONE |=> msg_error;
   endproperty
   property p_rsv;
      take && blk && (bsz > 3'h4 || (sub == 2'h3 && bsz == 3'h0)
         || (sub == 2'h2 && bsz != 3'h1 && bsz != 3'h3)) |=> msg_error;
   endproperty
   property p_unal; take && blk && sub == 2'h1 && msg_write |=> msg_error;
   endproperty
   property p_lanes;
      out_valid && !msg_ready && kind_q == msg_pkg::KIND_CMPWR64
         |-> (out_dw_en & 8'hcc) == 8'h00;
   endproperty
   property p_inval;
      take && blk && !msg_write |=> inval_after_read == $past(msg_desc[13]);
   endproperty
   property p_wr; take && msg_write |=> !inval_after_read; endproperty
   property p_off;
      take |=> block_off0 == $past(hdr_off0) && block_off1 == $past(hdr_off1);
   endproperty
   a_noret : assert property (p_noret)
      else $error("data moved");
   a_busy : assert property (p_busy)
      else $error("ready after take");
   a_done : assert property (p_done)
      else $error("long done");
   a_kind : assert property (p_kind)
      else $error("kind unflagged");
   a_rsv : assert property (p_rsv)
      else $error("size unflagged");
   a_unal : assert property (p_unal)
      else $error("unaligned write");
   a_lanes : assert property (p_lanes)
      else $error("reserved dwords");
   a_inval : assert property (p_inval)
      else $error("read invalidate");
   a_wr : assert property (p_wr)
      else $error("write invalidate");
   a_off : assert property (p_off)
      else $error("offsets");
endmodule // data_port_block_message_decode_asserts

bind data_port_block_message_decode
   data_port_block_message_decode_asserts i_asserts (.*);

//--- dv/thread_side.sv
// Thread-side model: payload or read beats and writeback sink
`timescale 1ns/1ps
module thread_side (
   input  wire logic    clk, // Core clock
   input  wire logic    take, // Message taken this edge
   input  wire logic    stall, // Throttle both sides
   input  wire logic    beat_ready, // Beat accepted
   output logic         beat_valid = 1'b0, // Beat offered
   output logic [255:0] beat_data = 256'h0, // Beat word
   output logic         out_ready = 1'b0 // Writeback sink ready
);
   int idx = 0; // Beats moved this message
   bit ph = 1'b0; // Stall phase
   // Dword j of beat i carries i and j
   function automatic logic [255:0] pat(int i);
      for (int j = 0; j < 8; j++) pat[j*32 +: 32] = 32'h1000_0000 + 32'(i*16+j);
   endfunction
   // Count handshakes, restart per message
   always @(posedge clk) idx <= take ? 0 : idx + int'(beat_valid && beat_ready);
   // Drive after the falling edge; idle data is inverted
   always @(negedge clk) begin
      ph <= ~ph;
      beat_valid <= !(stall && ph);
      beat_data <= (stall && ph) ? ~pat(idx) : pat(idx);
      out_ready <= !(stall && !ph);
   end
endmodule // thread_side

//--- dv/data_port_block_message_decode_test.sv
// Self-checking bench for the block message decoder
`timescale 1ns/1ps
`define CHK(nm, ex, ob) begin tests_run++; if ((ob) !== (ex)) begin \
   err_total++; $display("CHECK FAILED %s exp %h got %h", nm, ex, ob); end end
module data_port_block_message_decode_test;
   typedef struct {logic [1:0] k; logic w; logic [15:0] d; logic cm;
      logic [15:0] x; int n; logic [7:0] e; int s; logic r;} row_t;
   logic clk = 1'b0, rst_n = 1'b0, msg_valid = 1'b0, msg_write = 1'b0;
   logic [1:0] kind = 2'h0;                  // Message kind code
   logic [31:0] desc = 32'h0, dw5 = 32'h0, dw7 = 32'h0000_00a5;
   logic [15:0] exec = 16'h0;                // Execution mask
   logic [63:0] ho0 = 64'h0000_7fff_ffff_ffe0, ho1 = 64'hffff_8000_0000_0000;
   logic stall = 1'b0, hdr_present = 1'b1;   // Throttle, header sent
   logic beat_valid, beat_ready, out_valid, out_ready, msg_ready, out_last;
   logic out_write, inval, msg_error, msg_done;
   logic [255:0] beat_data, out_data;        // Beat and output words
   logic [7:0] out_dw_en;                    // Dword enables
   logic [63:0] off0, off1;                  // Captured offsets
   int err_total = 0, tests_run = 0, cyc = 0;
   // Kind, write, desc, mode, exec, words, enables, layout, error
   row_t rows[20] = '{
      '{0,0,16'h2000,0,16'hffff,1,8'h0f,1,0}, '{0,0,16'h0100,0,16'hffff,1,8'hf0,1,0},
      '{0,1,16'h2100,0,16'hffff,1,8'h0f,2,0}, '{0,0,16'h0400,0,16'h0f01,4,8'h0f,0,0},
      '{0,0,16'h0300,0,16'h0f01,2,8'h0f,0,0}, '{0,0,16'h0b00,0,16'h0f01,2,8'h0f,0,0},
      '{0,0,16'h1300,0,16'hffff,4,8'hff,0,0}, '{0,0,16'h1c00,0,16'h0f01,8,8'h0f,0,0},
      '{0,1,16'h1a00,1,16'h0f01,2,8'h01,0,0}, '{0,0,16'h1900,0,16'hffff,1,8'hff,0,0},
      '{1,0,16'h2000,0,16'h00f0,1,8'h30,3,0}, '{2,0,16'h3000,0,16'h00ff,1,8'ha5,0,0},
      '{2,0,16'h2000,0,16'hffff,2,8'ha5,0,0}, '{2,0,16'h3800,0,16'hffff,2,8'ha5,0,0},
      '{0,0,16'h1000,0,16'hffff,0,8'h0,0,1}, '{0,0,16'h1800,0,16'hffff,0,8'h0,0,1},
      '{0,0,16'h0500,0,16'hffff,0,8'h0,0,1}, '{0,1,16'h0b00,0,16'hffff,0,8'h0,0,1},
      '{3,0,16'h0000,0,16'hffff,0,8'h0,0,1},
      '{1,0,16'h0000,0,16'hffff,0,8'h0,0,0}};
   always #50 clk = ~clk;
   data_port_block_message_decode i_data_port_block_message_decode (
      .clk, .rst_n, .ce(1'b1), .msg_valid, .msg_ready,
      .msg_kind(msg_pkg::kind_t'(kind)), .msg_write, .msg_desc(desc),
      .hdr_present, .hdr_dw5(dw5), .hdr_dw7(dw7), .hdr_off0(ho0),
      .hdr_off1(ho1), .exec_mask(exec), .beat_valid, .beat_ready, .beat_data,
      .out_valid, .out_ready, .out_data, .out_dw_en, .out_last, .out_write,
      .inval_after_read(inval), .block_off0(off0), .block_off1(off1),
      .msg_error, .msg_done);
   thread_side i_thread_side (.clk, .take(msg_valid && msg_ready), .stall,
      .beat_ready, .beat_valid, .beat_data, .out_ready);
   // Expected word layout from a beat
   function automatic logic [255:0] xw(int s, logic [255:0] b);
      case (s)
         1: xw = {2{b[127:0]}};
         2: xw = {2{b[255:128]}};
         3: xw = {{2{b[127:64]}}, {2{b[63:0]}}};
         default: xw = b;
      endcase
   endfunction
   // Dword enables widened to bits
   function automatic logic [255:0] mask(logic [7:0] e);
      for (int j = 0; j < 8; j++) mask[j*32 +: 32] = {32{e[j]}};
   endfunction
   // One message: offer, then collect the writeback words
   task automatic run(input row_t r);
      int c = 0, g = 0, d = 0;
      logic er = 1'b0;
      logic [255:0] m;
      @(negedge clk);
      while (!msg_ready && g++ < 50) @(negedge clk);
      {kind, msg_write, desc, exec} = {r.k, r.w, 16'h0, r.d, r.x};
      dw5 = {r.cm, 31'h0};
      msg_valid = 1'b1;
      @(negedge clk);
      msg_valid = 1'b0;
      `CHK("inval", r.k == 2'h0 && !r.w && r.d[13], inval)
      `CHK("offset", {ho0, ho1}, {off0, off1})
      g = 0;
      while (g++ < 200 && (d < 3 || c < r.n)) begin
         #1;
         if (out_valid && out_ready) begin
            m = mask(out_dw_en);
            if (c == 0) `CHK("enables", r.e, out_dw_en)
            `CHK("data", xw(r.s, i_thread_side.pat(c)) & m, out_data & m)
            c++;
         end
         er |= msg_error;
         if (msg_done || d > 0) d++;
         @(negedge clk);
      end
      `CHK("words", r.n, c)
      `CHK("error", r.r, er)
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      if (++cyc == 4000) begin
         err_total++;
         close_out();
      end
   end
   // Main sequence: table twice, then reset in mid-message
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      for (int p = 0; p < 2; p++) begin
         stall <= p[0];
         foreach (rows[i]) run(rows[i]);
      end
      {kind, msg_write, desc, msg_valid} = {2'h0, 1'b0, 32'h1c00, 1'b1};
      repeat (4) @(negedge clk);
      {rst_n, msg_valid} = 2'b00;
      repeat (3) @(negedge clk);
      `CHK("reset", 3'h0, {msg_ready, out_valid, msg_done})
      rst_n = 1'b1;
      run(rows[0]);
      close_out();
   end
endmodule // data_port_block_message_decode_test
